// *** epci_core_model.sv ***
// core model entering the requested vector
`timescale 1ns/1ns
module epci_core_model #(parameter int WAIT = 2) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_in,
  input wire logic [2:0] idx_in,
  output logic ack_out,
  output logic [2:0] ack_idx_out,
  output int acks_out
);
  int cnt;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      ack_out <= 1'b0;
      ack_idx_out <= 3'h0;
      acks_out <= 0;
    end else if (ack_out) begin
      ack_out <= 1'b0;
      cnt <= 0;
    end else if (req_in && cnt == WAIT) begin
      ack_out <= 1'b1;
      ack_idx_out <= idx_in;
      acks_out <= acks_out + 1;
    end else if (req_in) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
    end
  end
endmodule // epci_core_model

// *** epci_pkg.sv ***
// constants for the external and pin-change interrupt block
package epci_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PC_PINS = 28;
  localparam int NUM_SRC = 6;
  localparam int VADDR_W = 12;
  // register offsets
  localparam logic [7:0] OFS_GROUP_EN = 8'h68;
  localparam logic [7:0] OFS_SENSE = 8'h69;
  localparam logic [7:0] OFS_MASK_LOW = 8'h6B;
  localparam logic [7:0] OFS_MASK_MID = 8'h6C;
  localparam logic [7:0] OFS_MASK_HIGH = 8'h6D;
  localparam logic [7:0] OFS_MASK_TOP = 8'h6E;
  localparam logic [7:0] OFS_CORE_CTRL = 8'h55;
  localparam logic [7:0] OFS_EXT_MASK = 8'h3D;
  localparam logic [7:0] OFS_EXT_FLAGS = 8'h3C;
  localparam logic [7:0] OFS_GROUP_FLAGS = 8'h3B;
  localparam logic [7:0] OFS_PROTECT = 8'h2F;
  // field positions
  localparam int VSEL_BIT = 1;
  localparam int SENSE_A_LSB = 0;
  localparam int SENSE_B_LSB = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic [1:0] RST_PAIR = 2'h0;
  // signature that opens the protected window, value is arbitrary
  localparam logic [7:0] PROTECT_SIG = 8'hA5;
  // protected window, four instruction cycles of one clock each
  localparam int PROTECT_INSTR = 4;
  localparam int CLK_PER_INSTR = 1;
  localparam logic [2:0] PROTECT_CYC = 3'(PROTECT_INSTR * CLK_PER_INSTR);
  // sense modes
  typedef enum logic [1:0] {
    EPCI_LOW   = 2'h0,
    EPCI_ANY   = 2'h1,
    EPCI_FALL  = 2'h2,
    EPCI_RISE  = 2'h3
  } epci_sense_e;
  // boot section start, word address, per boot size fuse setting
  localparam logic [11:0] BOOT_BASE_0 = 12'h800;
  localparam logic [11:0] BOOT_BASE_1 = 12'hC00;
  localparam logic [11:0] BOOT_BASE_2 = 12'hE00;
  localparam logic [11:0] BOOT_BASE_3 = 12'hF00;
  localparam logic [11:0] APP_BASE = 12'h000;
  localparam logic [11:0] VEC_FIRST = 12'h001;
  localparam logic [2:0] SRC_EXT_A = 3'h0;
  localparam logic [2:0] SRC_EXT_B = 3'h1;
  localparam logic [2:0] SRC_GROUP0 = 3'h2;
endpackage : epci_pkg

// *** epci_top.sv ***
// external pin and pin-change interrupt controller
`timescale 1ns/1ns
// Functional notes
// - vector select zero puts vectors at flash start, one at boot section
// - boot section start comes from boot size fuses only
// - vectors in boot and app lock set: block interrupts in application
// - vectors in app and boot lock set: block interrupts in boot code
// - vector select writes accepted only within four cycles of signature
// - pin enabled only when mask bit and group enable both set
// - unused upper bits of small registers read as zero
// - sense field: low, any change, falling, rising; B at 3:2, A at 1:0
// - pins sampled before edge detection; pulses over one clock caught
// - external request taken only with global flag and own mask bit
// - group enable with global flag lets enabled pin changes interrupt
// - mask bit 1 enables pin B, bit 0 pin A, each with own sense
// - pin activity requests even when pin is driven as output
// - flag B set on trigger, cleared on vector entry or write one
// - set flag with global and mask branches to its vector
// - flag held clear while its pin uses low level sensing
// - pin-change detection works without clock for wake up
// - group flag set on enabled change, cleared on entry or write one
module epci_top (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  input wire logic EXT_PIN_A_IN,
  input wire logic EXT_PIN_B_IN,
  input wire logic [27:0] PCHG_PIN_IN,
  input wire logic GLOBAL_IRQ_EN_IN,
  input wire logic EXEC_IN_BOOT_IN,
  input wire logic [1:0] BOOT_SIZE_FUSES_IN,
  input wire logic APP_IRQ_LOCK_IN,
  input wire logic BOOT_IRQ_LOCK_IN,
  input wire logic VEC_ACK_IN,
  input wire logic [2:0] VEC_ACK_IDX_IN,
  output logic IRQ_REQ_OUT,
  output logic [2:0] IRQ_IDX_OUT,
  output logic [11:0] IRQ_VEC_ADDR_OUT,
  output logic VECTOR_SEL_OUT,
  output logic WAKE_OUT
);

  localparam int NUM_SRC_LOC = epci_pkg::NUM_SRC;

  logic [3:0] group_en_reg;
  logic [3:0] sense_reg;
  logic [7:0] mask_low_reg;
  logic [7:0] mask_mid_reg;
  logic [7:0] mask_high_reg;
  logic [3:0] mask_top_reg;
  logic vsel_reg;
  logic [1:0] ext_mask_reg;
  logic [1:0] ext_flag_reg;
  logic [1:0] ext_flag_next;
  logic [3:0] grp_flag_reg;
  logic [3:0] grp_flag_next;
  logic [2:0] protect_cnt_reg;
  logic [29:0] sync1_reg;
  logic [29:0] sync2_reg;
  logic [29:0] prev_reg;
  logic [7:0] rdata_reg;
  logic irq_req_reg;
  logic [2:0] irq_idx_reg;
  logic [11:0] irq_addr_reg;
  logic [27:0] pin_mask;
  logic [27:0] pin_en;
  logic [27:0] pin_chg;
  logic [3:0] grp_trig;
  logic [1:0] ext_trig;
  logic [1:0] ext_level;
  logic [1:0] ext_low;
  logic [1:0] ext_rise;
  logic [1:0] ext_fall;
  logic [1:0] ext_sw_clr;
  logic [1:0] ext_hw_clr;
  logic [3:0] grp_sw_clr;
  logic [3:0] grp_hw_clr;
  logic [NUM_SRC_LOC-1:0] src_pend;
  logic irq_allowed;
  logic [11:0] vec_base;
  logic [11:0] boot_base;
  logic [2:0] pick_idx;
  logic pick_any;
  logic wr_ctrl_ok;

  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = REG_WR_IN && (REG_ADDR_IN == ofs);
  endfunction

  function automatic logic [1:0] sense_of(input logic [3:0] s,
                                          input int lsb);
    sense_of = s[lsb +: 2];
  endfunction

  function automatic logic trig_of(input logic [1:0] mode,
                                   input logic rise, input logic fall);
    unique case (mode)
      epci_pkg::EPCI_ANY: trig_of = rise | fall;
      epci_pkg::EPCI_FALL: trig_of = fall;
      epci_pkg::EPCI_RISE: trig_of = rise;
      default: trig_of = 1'b0;
    endcase
  endfunction

  // pin sampling: external B, external A, then 28 change pins
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= {EXT_PIN_B_IN, EXT_PIN_A_IN, PCHG_PIN_IN};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // pin-change detection
  assign pin_mask = {mask_top_reg, mask_high_reg, mask_mid_reg,
                     mask_low_reg};
  assign pin_chg = sync2_reg[27:0] ^ prev_reg[27:0];

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_grp
      localparam int LO = g * 8;
      localparam int W = (g == 3) ? 4 : 8;
      assign pin_en[LO +: W] = pin_mask[LO +: W] &
                               {W{group_en_reg[g]}};
      assign grp_trig[g] = |(pin_en[LO +: W] & pin_chg[LO +: W]);
    end
  endgenerate

  // external pin triggers
  assign ext_rise = sync2_reg[29:28] & ~prev_reg[29:28];
  assign ext_fall = ~sync2_reg[29:28] & prev_reg[29:28];
  assign ext_low = ~sync2_reg[29:28];

  generate
    for (g = 0; g < 2; g++) begin : g_ext
      localparam int LSB = (g == 0) ? epci_pkg::SENSE_A_LSB
                                    : epci_pkg::SENSE_B_LSB;
      // sense mode per pin
      assign ext_level[g] = (sense_of(sense_reg, LSB) ==
                             epci_pkg::EPCI_LOW);
      assign ext_trig[g] = trig_of(sense_of(sense_reg, LSB),
                                   ext_rise[g], ext_fall[g]);
    end
  endgenerate

  // asynchronous wake from enabled pin change or low level
  assign WAKE_OUT = (|(pin_en & (PCHG_PIN_IN ^ sync2_reg[27:0]))) |
                    (|(ext_mask_reg & ext_level &
                       ~{EXT_PIN_B_IN, EXT_PIN_A_IN}));

  // flag clear terms
  assign ext_sw_clr = wr_hit(epci_pkg::OFS_EXT_FLAGS) ?
                      REG_WDATA_IN[1:0] : 2'h0;
  assign grp_sw_clr = wr_hit(epci_pkg::OFS_GROUP_FLAGS) ?
                      REG_WDATA_IN[3:0] : 4'h0;
  generate
    for (g = 0; g < 2; g++) begin : g_ehw
      assign ext_hw_clr[g] = VEC_ACK_IN &&
        (VEC_ACK_IDX_IN == 3'(epci_pkg::SRC_EXT_A + 3'(g)));
    end
    for (g = 0; g < 4; g++) begin : g_ghw
      assign grp_hw_clr[g] = VEC_ACK_IN &&
        (VEC_ACK_IDX_IN == 3'(epci_pkg::SRC_GROUP0 + 3'(g)));
    end
  endgenerate

  // set wins over either clear; level mode holds flag clear
  assign ext_flag_next = ((ext_flag_reg & ~ext_sw_clr & ~ext_hw_clr) |
                          ext_trig) & ~ext_level;
  assign grp_flag_next = (grp_flag_reg & ~grp_sw_clr & ~grp_hw_clr) |
                         grp_trig;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ext_flag_reg <= epci_pkg::RST_PAIR;
    end else begin
      ext_flag_reg <= ext_flag_next;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      grp_flag_reg <= epci_pkg::RST_NIB;
    end else begin
      grp_flag_reg <= grp_flag_next;
    end
  end

  // protected window for vector select
  assign wr_ctrl_ok = wr_hit(epci_pkg::OFS_CORE_CTRL) &&
                      (protect_cnt_reg != 3'h0);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      protect_cnt_reg <= 3'h0;
    end else if (wr_hit(epci_pkg::OFS_PROTECT) &&
                 REG_WDATA_IN == epci_pkg::PROTECT_SIG) begin
      protect_cnt_reg <= epci_pkg::PROTECT_CYC;
    end else if (wr_ctrl_ok) begin
      protect_cnt_reg <= 3'h0;
    end else if (protect_cnt_reg != 3'h0) begin
      protect_cnt_reg <= protect_cnt_reg - 3'h1;
    end
  end

  // software registers
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      group_en_reg <= epci_pkg::RST_NIB;
    end else if (wr_hit(epci_pkg::OFS_GROUP_EN)) begin
      group_en_reg <= REG_WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      sense_reg <= epci_pkg::RST_NIB;
    end else if (wr_hit(epci_pkg::OFS_SENSE)) begin
      sense_reg <= REG_WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_low_reg <= epci_pkg::RST_BYTE;
    end else if (wr_hit(epci_pkg::OFS_MASK_LOW)) begin
      mask_low_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_mid_reg <= epci_pkg::RST_BYTE;
    end else if (wr_hit(epci_pkg::OFS_MASK_MID)) begin
      mask_mid_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_high_reg <= epci_pkg::RST_BYTE;
    end else if (wr_hit(epci_pkg::OFS_MASK_HIGH)) begin
      mask_high_reg <= REG_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mask_top_reg <= epci_pkg::RST_NIB;
    end else if (wr_hit(epci_pkg::OFS_MASK_TOP)) begin
      mask_top_reg <= REG_WDATA_IN[3:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ext_mask_reg <= epci_pkg::RST_PAIR;
    end else if (wr_hit(epci_pkg::OFS_EXT_MASK)) begin
      ext_mask_reg <= REG_WDATA_IN[1:0];
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      vsel_reg <= 1'b0;
    end else if (wr_ctrl_ok) begin
      vsel_reg <= REG_WDATA_IN[epci_pkg::VSEL_BIT];
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_reg <= epci_pkg::RST_BYTE;
    end else if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        epci_pkg::OFS_GROUP_EN: rdata_reg <= {4'h0, group_en_reg};
        epci_pkg::OFS_SENSE: rdata_reg <= {4'h0, sense_reg};
        epci_pkg::OFS_MASK_LOW: rdata_reg <= mask_low_reg;
        epci_pkg::OFS_MASK_MID: rdata_reg <= mask_mid_reg;
        epci_pkg::OFS_MASK_HIGH: rdata_reg <= mask_high_reg;
        epci_pkg::OFS_MASK_TOP: rdata_reg <= {4'h0, mask_top_reg};
        epci_pkg::OFS_CORE_CTRL: rdata_reg <= {6'h00, vsel_reg, 1'b0};
        epci_pkg::OFS_EXT_MASK: rdata_reg <= {6'h00, ext_mask_reg};
        epci_pkg::OFS_EXT_FLAGS: rdata_reg <= {6'h00, ext_flag_reg};
        epci_pkg::OFS_GROUP_FLAGS: rdata_reg <= {4'h0, grp_flag_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // vector base from fuses and select bit
  always_comb begin
    unique case (BOOT_SIZE_FUSES_IN)
      2'h0: boot_base = epci_pkg::BOOT_BASE_0;
      2'h1: boot_base = epci_pkg::BOOT_BASE_1;
      2'h2: boot_base = epci_pkg::BOOT_BASE_2;
      default: boot_base = epci_pkg::BOOT_BASE_3;
    endcase
  end
  assign vec_base = vsel_reg ? boot_base : epci_pkg::APP_BASE;

  // lock bits block interrupts in the other section
  assign irq_allowed = GLOBAL_IRQ_EN_IN &&
    !(vsel_reg && APP_IRQ_LOCK_IN && !EXEC_IN_BOOT_IN) &&
    !(!vsel_reg && BOOT_IRQ_LOCK_IN && EXEC_IN_BOOT_IN);

  // pending sources; level mode requests from the synchronised pin sample, not the flag
  generate
    for (g = 0; g < 2; g++) begin : g_epend
      assign src_pend[g] = ext_mask_reg[g] &&
        (ext_level[g] ? ext_low[g] : ext_flag_reg[g]);
    end
    for (g = 0; g < 4; g++) begin : g_gpend
      assign src_pend[g + 2] = group_en_reg[g] && grp_flag_reg[g];
    end
  endgenerate

  // lowest index wins
  always_comb begin
    pick_idx = 3'h0;
    pick_any = 1'b0;
    for (int i = NUM_SRC_LOC - 1; i >= 0; i--) begin
      if (src_pend[i]) begin
        pick_idx = 3'(i);
        pick_any = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= pick_any && irq_allowed && !VEC_ACK_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_idx_reg <= 3'h0;
    end else begin
      irq_idx_reg <= pick_idx;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_addr_reg <= 12'h000;
    end else begin
      irq_addr_reg <= vec_base + epci_pkg::VEC_FIRST +
                      {9'h000, pick_idx};
    end
  end

  assign REG_RDATA_OUT = rdata_reg;
  assign IRQ_REQ_OUT = irq_req_reg;
  assign IRQ_IDX_OUT = irq_idx_reg;
  assign IRQ_VEC_ADDR_OUT = irq_addr_reg;
  assign VECTOR_SEL_OUT = vsel_reg;

endmodule // epci_top

// *** epci_top_assertions.sv ***
// port assertions for the interrupt block
`timescale 1ns/1ns
module epci_top_checker (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic GLOBAL_IRQ_EN_IN,
  input wire logic EXEC_IN_BOOT_IN,
  input wire logic [1:0] BOOT_SIZE_FUSES_IN,
  input wire logic APP_IRQ_LOCK_IN,
  input wire logic BOOT_IRQ_LOCK_IN,
  input wire logic VEC_ACK_IN,
  input wire logic IRQ_REQ_OUT,
  input wire logic [2:0] IRQ_IDX_OUT,
  input wire logic [11:0] IRQ_VEC_ADDR_OUT,
  input wire logic VECTOR_SEL_OUT
);
  logic [2:0] since_reg;
  logic [11:0] boot_base;
  wire logic ctl_ok = REG_WR_IN && REG_ADDR_IN == 8'h55 && since_reg != 3'h0;
  wire logic lk_app = VECTOR_SEL_OUT && APP_IRQ_LOCK_IN && !EXEC_IN_BOOT_IN;
  wire logic lk_boot = !VECTOR_SEL_OUT && BOOT_IRQ_LOCK_IN && EXEC_IN_BOOT_IN;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  // cycles since the signature write
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN)
      since_reg <= 3'h0;
    else if (REG_WR_IN && REG_ADDR_IN == 8'h2F && REG_WDATA_IN == 8'hA5)
      since_reg <= 3'h1;
    else if (since_reg != 3'h0 && since_reg != 3'h4)
      since_reg <= since_reg + 3'h1;
    else
      since_reg <= 3'h0;
  end
  always_comb begin
    case (BOOT_SIZE_FUSES_IN)
      2'h0: boot_base = 12'h800;
      2'h1: boot_base = 12'hC00;
      2'h2: boot_base = 12'hE00;
      default: boot_base = 12'hF00;
    endcase
  end
  AST_RSV_NIB: assert property (
    REG_RD_IN && REG_ADDR_IN inside {8'h68, 8'h69, 8'h6E, 8'h3B}
    |=> REG_RDATA_OUT[7:4] == 4'h0) else $error("upper nibble not zero");
  AST_RSV_EXT: assert property (
    REG_RD_IN && REG_ADDR_IN inside {8'h3C, 8'h3D}
    |=> REG_RDATA_OUT[7:2] == 6'h00) else $error("upper bits not zero");
  AST_NO_GIE: assert property (
    !GLOBAL_IRQ_EN_IN && !$past(GLOBAL_IRQ_EN_IN) |-> !IRQ_REQ_OUT)
    else $error("request without global enable");
  AST_ACK_DROP: assert property (
    VEC_ACK_IN |=> !IRQ_REQ_OUT) else $error("request held after entry");
  AST_VEC_ADDR: assert property (
    IRQ_REQ_OUT && $stable(VECTOR_SEL_OUT) |-> IRQ_VEC_ADDR_OUT ==
    (VECTOR_SEL_OUT ? boot_base : 12'h000) + 12'h001 + 12'(IRQ_IDX_OUT))
    else $error("wrong vector address");
  AST_LOCK_APP: assert property (
    lk_app && $past(lk_app) |-> !IRQ_REQ_OUT)
    else $error("request in application code");
  AST_LOCK_BOOT: assert property (
    lk_boot && $past(lk_boot) |-> !IRQ_REQ_OUT)
    else $error("request in boot code");
  AST_PROTECT: assert property (
    $changed(VECTOR_SEL_OUT) |-> $past(ctl_ok))
    else $error("vector select changed outside window");
endmodule // epci_top_checker
bind epci_top epci_top_checker i_epci_top_checker (.CLK_IN, .RST_IN,
  .REG_ADDR_IN, .REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT,
  .GLOBAL_IRQ_EN_IN, .EXEC_IN_BOOT_IN, .BOOT_SIZE_FUSES_IN, .APP_IRQ_LOCK_IN,
  .BOOT_IRQ_LOCK_IN, .VEC_ACK_IN, .IRQ_REQ_OUT, .IRQ_IDX_OUT,
  .IRQ_VEC_ADDR_OUT, .VECTOR_SEL_OUT);

// *** test_epci_top.sv ***
// testbench for the interrupt block
`timescale 1ns/1ns
module test_epci_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [1:0] ext = 2'b00;
  logic [27:0] pch = 28'h0;
  logic gie = 1'b0;
  logic in_boot = 1'b0;
  logic [7:0] rdata;
  logic ack;
  logic [2:0] ack_idx;
  logic req;
  logic [2:0] idx;
  logic [11:0] vaddr;
  logic vsel;
  logic wake;
  int acks;
  int err_count = 0;
  int checks = 0;
  localparam logic [7:0] OFS [11] = '{8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6D,
    8'h6E, 8'h3D, 8'h55, 8'h3C, 8'h3B, 8'h00};
  localparam logic [7:0] FULL [11] = '{8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'hFF,
    8'h0F, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
  always #4 clk = ~clk;
  epci_top i_epci_top (.CLK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s),
    .REG_RDATA_OUT(rdata), .EXT_PIN_A_IN(ext[0]), .EXT_PIN_B_IN(ext[1]),
    .PCHG_PIN_IN(pch), .GLOBAL_IRQ_EN_IN(gie), .EXEC_IN_BOOT_IN(in_boot),
    .BOOT_SIZE_FUSES_IN(2'h2), .APP_IRQ_LOCK_IN(1'b1),
    .BOOT_IRQ_LOCK_IN(1'b1), .VEC_ACK_IN(ack), .VEC_ACK_IDX_IN(ack_idx),
    .IRQ_REQ_OUT(req), .IRQ_IDX_OUT(idx), .IRQ_VEC_ADDR_OUT(vaddr),
    .VECTOR_SEL_OUT(vsel), .WAKE_OUT(wake));
  epci_core_model i_epci_core_model (.clk_in(clk), .rst_in(rst),
    .req_in(req), .idx_in(idx), .ack_out(ack), .ack_idx_out(ack_idx),
    .acks_out(acks));
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp,
    input string nm);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk({4'h0, rdata}, {4'h0, e}, "rdata");
    @(posedge clk);
  endtask
  task automatic wreq(input logic [2:0] i, input logic [11:0] b);
    int n;
    n = 0;
    #1;
    while (req !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({11'h0, req}, 12'h1, "req");
    chk({9'h0, idx}, {9'h0, i}, "idx");
    chk(vaddr, b + 12'h1 + 12'(i), "vec");
    repeat (5) @(posedge clk);
  endtask
  task automatic nreq();
    int a0;
    a0 = acks;
    repeat (10) @(posedge clk);
    chk(12'(acks - a0), 12'h0, "acks");
  endtask
  task automatic print_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    int i;
    int g;
    int k;
    int m;
    int p;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 11; i++) rchk(OFS[i], 8'h00);
    for (i = 0; i < 11; i++) wr(OFS[i], 8'hFF);
    for (i = 0; i < 11; i++) rchk(OFS[i], FULL[i]);
    for (i = 0; i < 11; i++) wr(OFS[i], 8'h00);
    for (k = 0; k < 2; k++) begin
      for (m = 1; m < 4; m++) begin
        wr(8'h69, 8'(m << (2 * k)));
        ext[k] <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(8'h3C, (m != 2) ? 8'(1 << k) : 8'h00);
        wr(8'h3C, 8'h03);
        ext[k] <= 1'b0;
        repeat (6) @(posedge clk);
        rchk(8'h3C, (m != 3) ? 8'(1 << k) : 8'h00);
        wr(8'h3C, 8'h03);
      end
    end
    gie <= 1'b1;
    ext <= 2'b11;
    wr(8'h69, 8'h08);
    wr(8'h3D, 8'h02);
    nreq();
    ext[1] <= 1'b0;
    wreq(3'h1, 12'h000);
    rchk(8'h3C, 8'h00);
    wr(8'h3D, 8'h01);
    ext[0] <= 1'b0;
    wreq(3'h0, 12'h000);
    chk({11'h0, wake}, 12'h1, "wake");
    ext[0] <= 1'b1;
    repeat (6) @(posedge clk);
    rchk(8'h3C, 8'h00);
    chk({11'h0, wake}, 12'h0, "wake");
    wr(8'h3D, 8'h00);
    for (g = 0; g < 4; g++) begin
      p = g * 8;
      wr(8'(8'h6B + g), 8'h02);
      wr(8'h68, 8'(1 << g));
      pch[p] <= ~pch[p];
      nreq();
      pch[p + 1] <= ~pch[p + 1];
      #1;
      chk({11'h0, wake}, 12'h1, "wake");
      wreq(3'(2 + g), 12'h000);
      rchk(8'h3B, 8'h00);
    end
    gie <= 1'b0;
    pch[25] <= ~pch[25];
    nreq();
    rchk(8'h3B, 8'h08);
    wr(8'h3B, 8'h08);
    rchk(8'h3B, 8'h00);
    gie <= 1'b1;
    in_boot <= 1'b1;
    pch[25] <= ~pch[25];
    nreq();
    in_boot <= 1'b0;
    wreq(3'h5, 12'h000);
    wr(8'h55, 8'h02);
    rchk(8'h55, 8'h00);
    chk({11'h0, vsel}, 12'h0, "vsel");
    wr(8'h2F, 8'hA5);
    wr(8'h55, 8'h02);
    rchk(8'h55, 8'h02);
    chk({11'h0, vsel}, 12'h1, "vsel");
    wr(8'h2F, 8'hA5);
    repeat (6) @(posedge clk);
    wr(8'h55, 8'h00);
    rchk(8'h55, 8'h02);
    pch[25] <= ~pch[25];
    nreq();
    in_boot <= 1'b1;
    wreq(3'h5, 12'hE00);
    print_verdict();
  end
endmodule // test_epci_top
